// ==== acc_limiter.sv ====
`timescale 1ns/10ps
module acc_limiter (
  input wire logic [zt_pkg::ACC_W-1:0] i_acc,
  output logic [zt_pkg::WORD_W-1:0] o_word,
  output logic o_limited
);
  import zt_pkg::*;

  logic ext_in_use;

  // Extension in use when bits 35..31 are not all the same sign
  assign ext_in_use = ~((&i_acc[35:31]) | ~(|i_acc[35:31]));
  assign o_limited = ext_in_use;
  // Saturate to the most positive or most negative word
  always_comb begin
    if (!ext_in_use) begin
      o_word = i_acc[31:16];
    end else if (i_acc[ACC_SIGN_BIT]) begin
      o_word = 16'h8000;
    end else begin
      o_word = 16'h7fff;
    end
  end
endmodule

// ==== op_cost.sv ====
`timescale 1ns/10ps
module op_cost (
  input wire zt_pkg::op_req_t i_req,
  output zt_pkg::op_cost_t o_cost
);
  import zt_pkg::*;

  always_comb begin
    o_cost.cycles = CYC_BASE;
    o_cost.words = WORDS_ONE;
    o_cost.illegal = 1'b0;
    if (i_req.accum_zero_test_op) begin
      // Base plus move extra, single word in every mode
      o_cost.cycles = CYC_BASE + i_req.parallel_move_extra_cycles;
      // Read into the tested accumulator is refused; writes are fine
      if (i_req.pmove == PM_READ &&
          ((i_req.pmove_reg == REG_A && !i_req.acc_sel_b) ||
           (i_req.pmove_reg == REG_B && i_req.acc_sel_b))) begin
        o_cost.illegal = 1'b1;
      end
    end else if (i_req.word_zero_test_op) begin
      unique case (i_req.mode)
        M_REG: o_cost.illegal = (i_req.src_reg == REG_HWS);
        M_IND, M_POSTINC, M_POSTDEC, M_POSTN, M_ABS6, M_IO6, M_AGU_DEC: begin
          o_cost.cycles = CYC_BASE;
        end
        M_IDXN, M_R2SHORT, M_SPSHORT: o_cost.cycles = CYC_MID;
        M_IDX16: begin
          o_cost.cycles = CYC_LONG;
          o_cost.words = WORDS_TWO;
        end
        M_ABS16: begin
          o_cost.cycles = CYC_MID;
          o_cost.words = WORDS_TWO;
        end
        default: o_cost.illegal = 1'b1;
      endcase
    end
  end
endmodule

// ==== tb_zero_test_condition_unit.sv ====
`timescale 1ns/10ps
module tb_zero_test_condition_unit;
  import zt_pkg::*;
  typedef struct packed {word_mode_t mode; logic [15:0] v; logic [3:0] c; logic [1:0] w;} row_t;
  logic i_clk = 0, i_arst_n = 0, i_start = 0, i_saturation_enable = 0, i_move_limited = 0;
  logic i_move_sz = 0, i_unnorm = 0, i_status_load_en = 0;
  op_req_t i_req = '0;
  op_req_t r;
  logic [35:0] i_acc_a = '0, i_acc_b = '0;
  logic [15:0] i_reg_word = '0, i_mem_word = '0, i_ptr_word = '0, i_status_load = '0;
  logic [15:0] o_status_word;
  logic o_busy, o_done, o_illegal, o_ptr_dec, o_pmove_go, o_pmove_write, o_pmove_postn;
  logic [1:0] o_words;
  logic [3:0] o_pmove_reg;
  logic [2:0] fl;
  int err_total = 0, n_checks = 0, cyc;
  row_t rows [13] = '{'{M_REG, 16'h0000, 4'h2, 2'h1}, '{M_IND, 16'h8001, 4'h2, 2'h1},
    '{M_POSTINC, 16'h1234, 4'h2, 2'h1}, '{M_POSTDEC, 16'h0000, 4'h2, 2'h1},
    '{M_POSTN, 16'h8001, 4'h2, 2'h1}, '{M_IDXN, 16'h1234, 4'h4, 2'h1},
    '{M_IDX16, 16'h8001, 4'h6, 2'h2}, '{M_R2SHORT, 16'h0000, 4'h4, 2'h1},
    '{M_SPSHORT, 16'h8001, 4'h4, 2'h1}, '{M_ABS6, 16'h1234, 4'h2, 2'h1},
    '{M_IO6, 16'h0000, 4'h2, 2'h1}, '{M_ABS16, 16'h8001, 4'h4, 2'h2},
    '{M_AGU_DEC, 16'h1234, 4'h2, 2'h1}};
  always #5 i_clk = ~i_clk;
  zero_test_condition_unit i_zero_test_condition_unit (.*);
  task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Returns cycles to done and the first-cycle pulses {ptr_dec, illegal, pmove_go}
  task automatic run(input op_req_t q);
    @(posedge i_clk) #1;
    i_req = q;
    i_start = 1;
    @(posedge i_clk) #1;
    i_start = 0;
    fl = {o_ptr_dec, o_illegal, o_pmove_go};
    cyc = 1;
    while (fl[1] !== 1'b1 && o_done !== 1'b1) begin
      @(posedge i_clk) #1;
      cyc++;
      if (cyc > 40) begin
        err_total++;
        stop_test();
      end
    end
  endtask
  initial begin
    repeat (8) @(posedge i_clk);
    #1 i_arst_n = 1;
    chk("reset status", o_status_word, STATUS_RESET);
    chk("reset outs", {o_busy, o_done, o_illegal, o_words}, 5'h0);
    i_status_load = 16'h8320;
    i_status_load_en = 1;
    @(posedge i_clk) #1 i_status_load_en = 0;
    foreach (rows[k]) begin
      r = '0;
      r.word_zero_test_op = 1;
      r.mode = rows[k].mode;
      i_reg_word = (r.mode == M_REG) ? rows[k].v : ~rows[k].v;
      i_ptr_word = (r.mode == M_AGU_DEC) ? rows[k].v : ~rows[k].v;
      i_mem_word = (r.mode inside {M_REG, M_AGU_DEC}) ? ~rows[k].v : rows[k].v;
      run(r);
      chk("cycles", cyc, rows[k].c);
      chk("words", o_words, rows[k].w);
      chk("ptr_dec", fl[2], r.mode inside {M_POSTDEC, M_AGU_DEC});
      chk("flags", o_status_word, {8'h83, 4'h2, rows[k].v[15], rows[k].v == 0, 2'h0});
    end
    $display("table done");
    i_acc_a = 36'h8_0203_0000;
    i_saturation_enable = 1;
    {i_unnorm, i_move_sz} = 2'h3;
    r = '0;
    r.accum_zero_test_op = 1;
    r.pmove = PM_READ;
    r.parallel_move_extra_cycles = 4'h3;
    r.pmove_reg = REG_Y1;
    r.pmove_postn = 1;
    run(r);
    chk("acc cycles", cyc, 5);
    chk("move side", {o_pmove_write, o_pmove_reg, o_pmove_postn}, {1'b0, REG_Y1, 1'b1});
    chk("acc move", {fl, o_words}, 5'h5);
    chk("acc flags", o_status_word, 16'h83b8);
    {i_unnorm, i_move_sz} = 2'h0;
    r.acc_sel_b = 1;
    r.pmove = PM_WRITE;
    r.pmove_reg = REG_B;
    r.pmove_postn = 0;
    r.parallel_move_extra_cycles = 4'h0;
    run(r);
    chk("acc b", {cyc[3:0], fl, o_status_word}, {4'h2, 3'h1, 16'h8304});
    chk("move wr", {o_pmove_write, o_pmove_reg, o_pmove_postn}, {1'b1, REG_B, 1'b0});
    r.acc_sel_b = 0;
    r.pmove = PM_READ;
    r.pmove_reg = REG_A;
    run(r);
    chk("clash", {fl, o_status_word}, {3'h2, 16'h8304});
    r = '0;
    r.word_zero_test_op = 1;
    r.src_reg = REG_HWS;
    run(r);
    chk("stack reg", {fl, o_status_word}, {3'h2, 16'h8304});
    i_acc_a = 36'h0_8000_0000;
    r.src_reg = REG_A;
    run(r);
    chk("limited", {cyc[3:0], o_status_word}, {4'h2, 16'h8340});
    i_acc_b = 36'hf_0000_0000;
    r.src_reg = REG_B;
    run(r);
    chk("limited b", {cyc[3:0], o_status_word}, {4'h2, 16'h8348});
    $display("hand tests done");
    stop_test();
  end
endmodule

// ==== zero_test_condition_unit.sv ====
`timescale 1ns/10ps
module zero_test_condition_unit (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_start,
  input wire zt_pkg::op_req_t i_req,
  input wire logic [zt_pkg::ACC_W-1:0] i_acc_a,
  input wire logic [zt_pkg::ACC_W-1:0] i_acc_b,
  input wire logic [zt_pkg::WORD_W-1:0] i_reg_word,
  input wire logic [zt_pkg::WORD_W-1:0] i_mem_word,
  input wire logic [zt_pkg::WORD_W-1:0] i_ptr_word,
  input wire logic i_saturation_enable,
  input wire logic i_move_limited,
  input wire logic i_move_sz,
  input wire logic i_unnorm,
  input wire logic [15:0] i_status_load,
  input wire logic i_status_load_en,
  output logic [15:0] o_status_word,
  output logic o_busy,
  output logic o_done,
  output logic o_illegal,
  output logic [1:0] o_words,
  output logic o_ptr_dec,
  output logic o_pmove_go,
  output logic o_pmove_write,
  output logic [3:0] o_pmove_reg,
  output logic o_pmove_postn
);
  import zt_pkg::*;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } state_t;

  state_t state_reg;
  logic [3:0] cnt_reg;
  op_req_t req_reg;
  op_cost_t cost;
  logic [WORD_W-1:0] lim_word;
  logic lim_flag;
  logic [ACC_W-1:0] acc_sel;
  logic [WORD_W-1:0] word_val;
  logic [7:0] flag_next;
  logic accept;

  op_cost u_cost (
    .i_req(i_req),
    .o_cost(cost)
  );

  // Saturation setting is deliberately not an input of this path
  // The word test names its accumulator through the source register, not the test select
  assign acc_sel = (i_req.word_zero_test_op && !i_req.accum_zero_test_op) ?
                   ((i_req.src_reg == REG_B) ? i_acc_b : i_acc_a) :
                   (i_req.acc_sel_b ? i_acc_b : i_acc_a);

  acc_limiter u_lim (
    .i_acc(acc_sel),
    .o_word(lim_word),
    .o_limited(lim_flag)
  );

  assign accept = (state_reg == ST_IDLE) && i_start &&
                  (i_req.accum_zero_test_op || i_req.word_zero_test_op);

  // Pick the 16-bit operand for the word test
  always_comb begin
    word_val = i_mem_word;
    if (i_req.mode == M_REG) begin
      if (i_req.src_reg == REG_A || i_req.src_reg == REG_B) begin
        word_val = lim_word;
      end else begin
        word_val = i_reg_word;
      end
    end else if (i_req.mode == M_AGU_DEC) begin
      word_val = i_ptr_word;
    end
  end

  // Flag computation; only the low byte is touched
  always_comb begin
    flag_next = o_status_word[7:0];
    if (i_req.accum_zero_test_op) begin
      flag_next[FLAG_SZ] = i_move_sz;
      flag_next[FLAG_L] = o_status_word[FLAG_L] | i_move_limited;
      flag_next[FLAG_E] = lim_flag;
      flag_next[FLAG_U] = i_unnorm;
      flag_next[FLAG_N] = acc_sel[ACC_SIGN_BIT];
      flag_next[FLAG_Z] = (acc_sel == '0);
      flag_next[FLAG_V] = 1'b0;
      flag_next[FLAG_C] = 1'b0;
    end else begin
      // Extension flag left alone by the word
      flag_next[FLAG_L] = o_status_word[FLAG_L] |
                          ((i_req.mode == M_REG) && lim_flag &&
                           (i_req.src_reg == REG_A || i_req.src_reg == REG_B));
      flag_next[FLAG_N] = word_val[WORD_W-1];
      flag_next[FLAG_Z] = (word_val == '0);
      flag_next[FLAG_V] = 1'b0;
      flag_next[FLAG_C] = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 4'h0;
      req_reg <= '0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (accept && !cost.illegal) begin
            state_reg <= ST_RUN;
            cnt_reg <= cost.cycles - 4'h1;
            req_reg <= i_req;
          end
        end
        ST_RUN: begin
          if (cnt_reg <= 4'h1) begin
            state_reg <= ST_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Status word
  // ----------------------------------------
  // Flags settle when the op is taken, unless a status load wins that cycle; the result is never written back
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_status_word <= STATUS_RESET;
    end else if (i_status_load_en) begin
      o_status_word <= i_status_load;
    end else if (accept && !cost.illegal) begin
      o_status_word[7:0] <= flag_next;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_illegal <= 1'b0;
      o_words <= 2'h0;
    end else begin
      o_illegal <= accept && cost.illegal;
      if (accept) begin
        o_words <= cost.words;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_busy <= (state_reg == ST_RUN && cnt_reg > 4'h1) || (accept && !cost.illegal);
      o_done <= (state_reg == ST_RUN) && (cnt_reg <= 4'h1);
    end
  end

  // ----------------------------------------
  // Side effects: pointer step and parallel move
  // ----------------------------------------
  // Move runs beside the test; the core's AGU does the pointer update
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_ptr_dec <= 1'b0;
      o_pmove_go <= 1'b0;
      o_pmove_write <= 1'b0;
      o_pmove_reg <= 4'h0;
      o_pmove_postn <= 1'b0;
    end else begin
      o_ptr_dec <= accept && !cost.illegal && i_req.word_zero_test_op &&
                   (i_req.mode == M_AGU_DEC || i_req.mode == M_POSTDEC);
      o_pmove_go <= accept && !cost.illegal && i_req.accum_zero_test_op &&
                    (i_req.pmove != PM_NONE);
      if (accept) begin
        o_pmove_write <= (i_req.pmove == PM_WRITE);
        o_pmove_reg <= i_req.pmove_reg;
        o_pmove_postn <= i_req.pmove_postn;
      end
    end
  end
endmodule

// ==== zero_test_condition_unit_chk.sv ====
`timescale 1ns/10ps
module zero_test_condition_unit_chk (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_start,
  input wire zt_pkg::op_req_t i_req,
  input wire logic [zt_pkg::ACC_W-1:0] i_acc_a,
  input wire logic [zt_pkg::ACC_W-1:0] i_acc_b,
  input wire logic i_status_load_en,
  input wire logic [15:0] o_status_word,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic o_illegal,
  input wire logic [1:0] o_words,
  input wire logic o_ptr_dec
);
  import zt_pkg::*;
  logic [ACC_W-1:0] acc_sel;
  logic go;
  assign acc_sel = i_req.acc_sel_b ? i_acc_b : i_acc_a;
  // A status write in the take cycle would mask the flag update
  assign go = !o_busy && i_start && !i_status_load_en;
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);
  sequence s_take_acc;
    go && i_req.accum_zero_test_op && !i_req.word_zero_test_op;
  endsequence
  sequence s_take_word;
    go && i_req.word_zero_test_op && !i_req.accum_zero_test_op;
  endsequence
  a_acc_flags: assert property (s_take_acc |=> o_illegal ||
    (o_status_word[FLAG_N] == $past(acc_sel[ACC_SIGN_BIT]) && o_status_word[1:0] == 2'h0
    && o_status_word[FLAG_Z] == ($past(acc_sel) == '0))) else $error("acc test flags wrong");
  a_word_vc_clear: assert property (s_take_word |=> o_illegal ||
    o_status_word[1:0] == 2'h0) else $error("word test left V or C set");
  a_word_keeps_ext: assert property (s_take_word |=>
    $stable(o_status_word[FLAG_E])) else $error("word test changed E");
  a_mode_half_kept: assert property (!i_status_load_en |=>
    $stable(o_status_word[15:8])) else $error("mode half changed");
  a_hws_refused: assert property (s_take_word ##0 (i_req.mode == M_REG &&
    i_req.src_reg == REG_HWS) |=> o_illegal && $stable(o_status_word))
    else $error("stack register operand accepted");
  a_read_clash: assert property (s_take_acc ##0 (i_req.pmove == PM_READ &&
    i_req.pmove_reg == (i_req.acc_sel_b ? REG_B : REG_A)) |=> o_illegal)
    else $error("read into tested accumulator accepted");
  a_acc_two_cyc: assert property (s_take_acc ##0 (i_req.pmove == PM_NONE &&
    i_req.parallel_move_extra_cycles == 4'h0) |=> o_busy && o_words == WORDS_ONE
    ##1 o_done && !o_busy) else $error("plain acc test not two cycles");
  a_long_disp_six: assert property (s_take_word ##0 (i_req.mode == M_IDX16) |=>
    o_busy && o_words == WORDS_TWO ##0 o_busy [*5] ##1 o_done)
    else $error("long displacement cost wrong");
  a_ptr_dec_pulse: assert property (s_take_word ##0 (i_req.mode == M_AGU_DEC) |=>
    o_ptr_dec) else $error("pointer not decremented");
endmodule
bind zero_test_condition_unit zero_test_condition_unit_chk i_chk (.*);

// ==== zt_pkg.sv ====
package zt_pkg;
  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int ACC_W = 36;
  localparam int WORD_W = 16;
  // ----------------------------------------
  // Flag byte bit positions
  // ----------------------------------------
  localparam int FLAG_SZ = 7;
  localparam int FLAG_L = 6;
  localparam int FLAG_E = 5;
  localparam int FLAG_U = 4;
  localparam int FLAG_N = 3;
  localparam int FLAG_Z = 2;
  localparam int FLAG_V = 1;
  localparam int FLAG_C = 0;
  localparam int ACC_SIGN_BIT = 35;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  // ----------------------------------------
  // Cycle costs in oscillator clocks
  // ----------------------------------------
  localparam logic [3:0] CYC_BASE = 4'h2;
  localparam logic [3:0] CYC_MID = 4'h4;
  localparam logic [3:0] CYC_LONG = 4'h6;
  localparam logic [1:0] WORDS_ONE = 2'h1;
  localparam logic [1:0] WORDS_TWO = 2'h2;

  // Operand source registers
  typedef enum logic [3:0] {
    REG_X0 = 4'h0, REG_Y1 = 4'h1, REG_Y0 = 4'h2, REG_A = 4'h3, REG_B = 4'h4,
    REG_A1 = 4'h5, REG_B1 = 4'h6, REG_RN = 4'h7, REG_HWS = 4'h8, REG_OTHER = 4'h9
  } reg_sel_t;

  // Word test operand modes
  typedef enum logic [3:0] {
    M_REG = 4'h0, M_IND = 4'h1, M_POSTINC = 4'h2, M_POSTDEC = 4'h3, M_POSTN = 4'h4,
    M_IDXN = 4'h5, M_IDX16 = 4'h6, M_R2SHORT = 4'h7, M_SPSHORT = 4'h8, M_ABS6 = 4'h9,
    M_IO6 = 4'ha, M_ABS16 = 4'hb, M_AGU_DEC = 4'hc
  } word_mode_t;

  // Parallel move kind
  typedef enum logic [1:0] {
    PM_NONE = 2'h0, PM_READ = 2'h1, PM_WRITE = 2'h2
  } pmove_t;

  typedef struct packed {
    logic accum_zero_test_op;
    logic word_zero_test_op;
    logic acc_sel_b;
    word_mode_t mode;
    reg_sel_t src_reg;
    pmove_t pmove;
    reg_sel_t pmove_reg;
    logic pmove_postn;
    logic [3:0] parallel_move_extra_cycles;
  } op_req_t;

  typedef struct packed {
    logic [3:0] cycles;
    logic [1:0] words;
    logic illegal;
  } op_cost_t;
endpackage
